// [sdc_dev.sv]
// Device end: decodes sampled command pins and tracks clock-enable state.
// Assumes the controller keeps the pin rules; async_clear_n low resets everything.
// Assumes the controller shares core_clk, so the link pins need no synchroniser.

module sdc_dev
    import sdc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    sdc_link_if.dev                link,
    output logic                   cmd_strobe,
    output sdc_cmd_t               cmd_kind,
    output logic [BANK_W-1:0]      cmd_bank,
    output logic [ADDR_W-1:0]      cmd_addr,
    output logic                   cmd_auto_close,
    output logic                   cmd_chop_four,
    output sdc_state_t             dev_state,
    output logic                   burst_busy,
    output logic [ADDR_W-1:0]      mode_zero
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Everything the device remembers; the four mode registers stay packed so that
    // the whole state is one register loaded by a single process.
    typedef struct packed {
        logic                   cke_prev;
        logic                   strobe;
        sdc_cmd_t               kind;
        logic [BANK_W-1:0]      bank;
        logic [ADDR_W-1:0]      addr;
        logic                   auto_close;
        logic                   chop_four;
        sdc_state_t             state;
        logic                   busy;
        logic [7:0]             open_banks;
        logic [BURST_CNT_W-1:0] burst_left;
        logic [3:0][ADDR_W-1:0] mode_regs;
    } sdc_dev_st_t;

    sdc_dev_st_t st;
    sdc_dev_st_t next_st;
    sdc_cmd_t    cmd;
    logic        arst;

    // Either reset pin clears the device without the clock.
    assign arst = rst | ~link.async_clear_n;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Settled state once no burst runs: any open row keeps the device active,
    // otherwise every bank is idle.
    function automatic sdc_state_t rest_state(input logic [7:0] banks);
        return (banks != 8'h00) ? SDC_ST_ACTIVE : SDC_ST_IDLE;
    endfunction

    // ----------------------------------------------------------------
    // Decode and state update
    // ----------------------------------------------------------------
    // Termination pin is left out of the decode on purpose.
    always_comb begin
        cmd = sdc_decode(st.cke_prev, link.clk_gate, link.chip_sel_n, link.row_strobe_n,
                         link.col_strobe_n, link.write_en_n, link.addr[AUTO_CLOSE_POS]);
        next_st          = st;
        next_st.cke_prev = link.clk_gate;
        next_st.strobe   = 1'b0;
        // A running burst counts down whatever the pins say; only a sleep command cuts it short.
        if (st.burst_left != '0) begin
            next_st.burst_left = st.burst_left - 1'b1;
        end else if (st.state == SDC_ST_BURST) begin
            next_st.state = rest_state(st.open_banks);
        end
        // Only a registered command raises the strobe and reloads the command fields.
        if (cmd != SDC_CMD_IDLE && cmd != SDC_CMD_ILLEGAL) begin
            next_st.strobe     = 1'b1;
            next_st.kind       = cmd;
            next_st.bank       = link.array_select;
            next_st.addr       = link.addr;
            next_st.auto_close = link.addr[AUTO_CLOSE_POS];
        end
        // Effects of each command on the banks, the burst and the power state.
        case (cmd)
            // The low two bank bits pick one of the four mode registers.
            SDC_CMD_MODE_SET: next_st.mode_regs[link.array_select[1:0]] = link.addr;
            // Self-refresh entry is honoured only with every bank idle.
            SDC_CMD_SR_ENTER: begin
                if (st.state == SDC_ST_IDLE) begin
                    next_st.state = SDC_ST_SELF_RENEW;
                end else begin
                    next_st.strobe = 1'b0;
                end
            end
            // Closing one bank or all of them; the idle check below settles the state.
            SDC_CMD_CLOSE:     next_st.open_banks[link.array_select] = 1'b0;
            SDC_CMD_CLOSE_ALL: next_st.open_banks = 8'h00;
            // Opening a row marks its bank and wakes an idle device into active.
            SDC_CMD_OPEN: begin
                next_st.open_banks[link.array_select] = 1'b1;
                if (st.state == SDC_ST_IDLE) begin
                    next_st.state = SDC_ST_ACTIVE;
                end
            end
            SDC_CMD_WRITE,
            SDC_CMD_READ: begin
                // Column address: bit 11 and bits 9:0 only.
                next_st.addr = link.addr & COL_ADDR_MASK;
                next_st.chop_four = st.mode_regs[MODE_REG_ZERO][FLY_SEL_POS] &&
                                    !link.addr[CHOP_SEL_POS];
                if (st.burst_left == '0) begin
                    next_st.burst_left = next_st.chop_four ? CHOP_FOUR_LEN : BURST_EIGHT_LEN;
                    next_st.state      = SDC_ST_BURST;
                end
                if (link.addr[AUTO_CLOSE_POS]) begin
                    next_st.open_banks[link.array_select] = 1'b0;
                end
            end
            // The power-down flavour follows what the device was doing.
            SDC_CMD_SLEEP: begin
                case (st.state)
                    SDC_ST_ACTIVE: next_st.state = SDC_ST_PD_ACTIVE;
                    SDC_ST_IDLE:   next_st.state = SDC_ST_PD_PRECHARGE;
                    default:       next_st.state = SDC_ST_PD_PLAIN;
                endcase
                next_st.burst_left = '0;
            end
            SDC_CMD_WAKE: begin
                // Exits sleep or self-refresh on the same edge.
                next_st.state = rest_state(st.open_banks);
            end
            default: ;
        endcase
        // Closing the last open row, by command or by auto-close, leaves every bank idle.
        if (next_st.state == SDC_ST_ACTIVE) begin
            next_st.state = rest_state(next_st.open_banks);
        end
        next_st.busy = (next_st.state == SDC_ST_BURST);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Cleared by either reset; the reset branch loads constants only.
    always_ff @(posedge core_clk or posedge arst) begin
        if (arst) begin
            st.cke_prev   <= 1'b1;
            st.strobe     <= 1'b0;
            st.kind       <= SDC_CMD_IDLE;
            st.bank       <= '0;
            st.addr       <= '0;
            st.auto_close <= 1'b0;
            st.chop_four  <= 1'b0;
            st.state      <= SDC_ST_IDLE;
            st.busy       <= 1'b0;
            st.open_banks <= 8'h00;
            st.burst_left <= '0;
            st.mode_regs  <= {4{MODE_RESET}};
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output is a field of the state register.
    assign cmd_strobe     = st.strobe;
    assign cmd_kind       = st.kind;
    assign cmd_bank       = st.bank;
    assign cmd_addr       = st.addr;
    assign cmd_auto_close = st.auto_close;
    assign cmd_chop_four  = st.chop_four;
    assign dev_state      = st.state;
    assign burst_busy     = st.busy;
    assign mode_zero      = st.mode_regs[MODE_REG_ZERO];

endmodule // sdc_dev

// [sdc_pkg.sv]
// Shared constants and types for the command decode link.
// Assumes one clock, core_clk, shared by the controller and the device.
package sdc_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int BANK_W         = 3;
    localparam int ADDR_W         = 16;
    localparam int AUTO_CLOSE_POS = 10;
    localparam int CHOP_SEL_POS   = 12;
    localparam int FLY_SEL_POS    = 0;
    localparam int BURST_CNT_W    = 3;
    localparam logic [BURST_CNT_W-1:0] BURST_EIGHT_LEN = 3'h7;
    localparam logic [BURST_CNT_W-1:0] CHOP_FOUR_LEN   = 3'h3;
    localparam logic [1:0] MODE_REG_ZERO = 2'h0;
    localparam logic [ADDR_W-1:0] MODE_RESET = 16'h0000;
    localparam int CKE_HOLD_EDGES = 3;
    localparam logic [1:0] CKE_HOLD_CNT = 2'h3;
    localparam logic [ADDR_W-1:0] COL_ADDR_MASK = 16'h0bff;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SDC_CMD_IDLE, SDC_CMD_MODE_SET, SDC_CMD_RENEW, SDC_CMD_SR_ENTER, SDC_CMD_CLOSE,
        SDC_CMD_CLOSE_ALL, SDC_CMD_OPEN, SDC_CMD_WRITE, SDC_CMD_READ, SDC_CMD_CAL_LONG,
        SDC_CMD_CAL_SHORT, SDC_CMD_SLEEP, SDC_CMD_WAKE, SDC_CMD_ILLEGAL
    } sdc_cmd_t;

    typedef enum logic [2:0] {
        SDC_ST_IDLE, SDC_ST_ACTIVE, SDC_ST_BURST, SDC_ST_PD_ACTIVE,
        SDC_ST_PD_PRECHARGE, SDC_ST_PD_PLAIN, SDC_ST_SELF_RENEW
    } sdc_state_t;

    // Decodes strobes into a command class; clock-enable pair included.
    function automatic sdc_cmd_t sdc_decode(input logic cke_prev, input logic cke_now, input logic cs_n,
                                            input logic ras_n, input logic cas_n, input logic we_n,
                                            input logic auto_close_bit);
        sdc_cmd_t c;
        logic     nopish;
        c      = SDC_CMD_ILLEGAL;
        nopish = cs_n | (ras_n & cas_n & we_n);
        if (!cke_prev) begin
            c = (cke_now && nopish) ? SDC_CMD_WAKE : (cke_now ? SDC_CMD_ILLEGAL : SDC_CMD_IDLE);
        end else if (!cke_now) begin
            if (nopish) begin
                c = SDC_CMD_SLEEP;
            end else if (!ras_n && !cas_n && we_n) begin
                c = SDC_CMD_SR_ENTER;
            end
        end else if (cs_n) begin
            c = SDC_CMD_IDLE;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h0:    c = SDC_CMD_MODE_SET;
                3'h1:    c = SDC_CMD_RENEW;
                3'h2:    c = auto_close_bit ? SDC_CMD_CLOSE_ALL : SDC_CMD_CLOSE;
                3'h3:    c = SDC_CMD_OPEN;
                3'h4:    c = SDC_CMD_WRITE;
                3'h5:    c = SDC_CMD_READ;
                3'h6:    c = auto_close_bit ? SDC_CMD_CAL_LONG : SDC_CMD_CAL_SHORT;
                default: c = SDC_CMD_IDLE;
            endcase
        end
        return c;
    endfunction

endpackage

// [sdc_link_if.sv]
// Command pins between a memory controller and the device.
// Assumes both ends run on the same core_clk.
interface sdc_link_if;
    import sdc_pkg::*;
    logic              chip_sel_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              write_en_n;
    logic              clk_gate;
    logic [BANK_W-1:0] array_select;
    logic [ADDR_W-1:0] addr;
    logic              termination_ctrl;
    logic              async_clear_n;

    modport ctrl (output chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, clk_gate,
                  array_select, addr, termination_ctrl, async_clear_n);
    modport dev  (input chip_sel_n, row_strobe_n, col_strobe_n, write_en_n, clk_gate,
                  array_select, addr, termination_ctrl, async_clear_n);
endinterface

// [sdc_ctrl.sv]
// Controller end: turns one-cycle user requests into pin commands.
// Assumes the device samples the pins on the same core_clk rising edge.
module sdc_ctrl
    import sdc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    sdc_link_if.ctrl               link,
    input  wire logic              req_valid,
    input  wire sdc_cmd_t          req_cmd,
    input  wire logic [BANK_W-1:0] req_bank,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic              req_term,
    output logic                   req_ready
);

    typedef struct packed {
        logic              cs_n;
        logic              ras_n;
        logic              cas_n;
        logic              we_n;
        logic              cke;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic              term;
        logic [1:0]        hold;
        logic              ready;
    } sdc_ctrl_st_t;

    sdc_ctrl_st_t st;
    sdc_ctrl_st_t next_st;

    // ----------------------------------------------------------------
    // Command issue
    // ----------------------------------------------------------------
    // Defaults to a no-op each cycle; a clock-enable change blocks new requests until held.
    always_comb begin
        next_st       = st;
        next_st.cs_n  = 1'b0;
        next_st.ras_n = 1'b1;
        next_st.cas_n = 1'b1;
        next_st.we_n  = 1'b1;
        next_st.term  = req_term;
        if (st.hold != 2'h0) begin
            next_st.hold = st.hold - 2'h1;
        end else if (req_valid) begin
            next_st.bank = req_bank;
            next_st.addr = req_addr;
            case (req_cmd)
                SDC_CMD_MODE_SET:  {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h0;
                SDC_CMD_RENEW:     {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h1;
                SDC_CMD_CLOSE,
                SDC_CMD_CLOSE_ALL: {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h2;
                SDC_CMD_OPEN:      {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h3;
                SDC_CMD_WRITE:     {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h4;
                SDC_CMD_READ:      {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h5;
                SDC_CMD_CAL_LONG,
                SDC_CMD_CAL_SHORT: {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h6;
                SDC_CMD_SR_ENTER: begin
                    {next_st.ras_n, next_st.cas_n, next_st.we_n} = 3'h1;
                    next_st.cke  = 1'b0;
                    next_st.hold = CKE_HOLD_CNT;
                end
                SDC_CMD_SLEEP: begin
                    next_st.cke  = 1'b0;
                    next_st.hold = CKE_HOLD_CNT;
                end
                SDC_CMD_WAKE: begin
                    next_st.cke  = 1'b1;
                    next_st.hold = CKE_HOLD_CNT;
                end
                default: ;
            endcase
            if (req_cmd == SDC_CMD_CLOSE_ALL || req_cmd == SDC_CMD_CAL_LONG) begin
                next_st.addr[AUTO_CLOSE_POS] = 1'b1;
            end
            if (req_cmd == SDC_CMD_CLOSE || req_cmd == SDC_CMD_CAL_SHORT) begin
                next_st.addr[AUTO_CLOSE_POS] = 1'b0;
            end
        end
        next_st.ready = (next_st.hold == 2'h0);
    end

    // State register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cke: 1'b1,
                    bank: '0, addr: '0, term: 1'b0, hold: 2'h0, ready: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    assign link.chip_sel_n       = st.cs_n;
    assign link.row_strobe_n     = st.ras_n;
    assign link.col_strobe_n     = st.cas_n;
    assign link.write_en_n       = st.we_n;
    assign link.clk_gate         = st.cke;
    assign link.array_select     = st.bank;
    assign link.addr             = st.addr;
    assign link.termination_ctrl = st.term;
    assign link.async_clear_n    = 1'b1;
    assign req_ready             = st.ready;

endmodule // sdc_ctrl

// [sdc_checker.sv]
// Concurrent checks on the command pins between controller and device.
// Assumes one clock, core_clk, and the active high reset rst of both ends.
module sdc_checker
    import sdc_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              chip_sel_n,
    input wire logic              row_strobe_n,
    input wire logic              col_strobe_n,
    input wire logic              write_en_n,
    input wire logic              clk_gate,
    input wire logic [BANK_W-1:0] array_select,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              termination_ctrl,
    input wire logic              async_clear_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Pin decode helpers
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic       quiet;
    logic       renew;
    logic       open_cmd;
    logic       close_cmd;
    logic       burst_ac;
    logic [7:0] bank_open;
    // Deselect or no-op, and the refresh pattern used for self-refresh entry.
    assign quiet     = chip_sel_n | (row_strobe_n & col_strobe_n & write_en_n);
    assign renew     = !chip_sel_n & !row_strobe_n & !col_strobe_n & write_en_n;
    assign open_cmd  = clk_gate & !chip_sel_n & !row_strobe_n & col_strobe_n & write_en_n;
    assign close_cmd = clk_gate & !chip_sel_n & !row_strobe_n & col_strobe_n & !write_en_n;
    assign burst_ac  = clk_gate & !chip_sel_n & row_strobe_n & !col_strobe_n & addr[AUTO_CLOSE_POS];
    // Tracks which banks hold an open row as seen on the pins.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            bank_open <= 8'h00;
        end else if (open_cmd) begin
            bank_open[array_select] <= 1'b1;
        end else if (close_cmd && addr[AUTO_CLOSE_POS]) begin
            bank_open <= 8'h00;
        end else if (close_cmd || burst_ac) begin
            bank_open[array_select] <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence gate_held;
        $stable(clk_gate) [*2];
    endsequence
    cke_hold_a: assert property ($changed(clk_gate) |=> gate_held)
        else $error("clk_gate changed again too soon");
    clear_high_a: assert property (async_clear_n)
        else $error("async_clear_n low in operation");
    gate_steady_a: assert property (!quiet && !renew |-> clk_gate && $past(clk_gate))
        else $error("command issued without steady clk_gate");
    sleep_pins_a: assert property ($fell(clk_gate) |-> quiet || renew)
        else $error("clk_gate fell with a wrong command");
    wake_pins_a: assert property ($rose(clk_gate) |-> quiet)
        else $error("clk_gate rose without no-op");
    low_quiet_a: assert property (!clk_gate && !$past(clk_gate) |-> quiet)
        else $error("command while clk_gate held low");
    reset_pins_a: assert property (disable iff (1'b0) rst |=> chip_sel_n && clk_gate)
        else $error("pins not idle in reset");
    open_twice_a: assert property (open_cmd |-> !bank_open[array_select])
        else $error("row opened in a bank still open");
endmodule // sdc_checker

// [tb_sdc_command_decode.sv]
// Self-checking bench: controller and device joined by the link interface.
// Assumes the design package and both ends compile before this file.
module tb_sdc_command_decode
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
        $display("ERROR %0t: mismatch at line %0d", $time, `__LINE__); end end
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_valid = 1'b0;
    sdc_cmd_t          req_cmd = SDC_CMD_IDLE;
    logic [BANK_W-1:0] req_bank = 3'h0;
    logic [ADDR_W-1:0] req_addr = 16'h0000;
    logic              req_term = 1'b0;
    logic              req_ready;
    logic              cmd_strobe;
    sdc_cmd_t          cmd_kind;
    logic [BANK_W-1:0] cmd_bank;
    logic [ADDR_W-1:0] cmd_addr;
    logic              cmd_auto_close;
    logic              cmd_chop_four;
    sdc_state_t        dev_state;
    logic              burst_busy;
    logic [ADDR_W-1:0] mode_zero;
    int                error_cnt = 0;
    int                checks_done = 0;
    int                cycles = 0;
    sdc_link_if sdc_link_if_i ();
    sdc_ctrl sdc_ctrl_i (.core_clk(core_clk), .rst(rst), .link(sdc_link_if_i), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_term(req_term), .req_ready(req_ready));
    sdc_dev sdc_dev_i (.core_clk(core_clk), .rst(rst), .link(sdc_link_if_i), .cmd_strobe(cmd_strobe),
        .cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_auto_close(cmd_auto_close),
        .cmd_chop_four(cmd_chop_four), .dev_state(dev_state), .burst_busy(burst_busy), .mode_zero(mode_zero));
    sdc_checker sdc_checker_i (.core_clk(core_clk), .rst(rst), .chip_sel_n(sdc_link_if_i.chip_sel_n),
        .row_strobe_n(sdc_link_if_i.row_strobe_n), .col_strobe_n(sdc_link_if_i.col_strobe_n),
        .write_en_n(sdc_link_if_i.write_en_n), .clk_gate(sdc_link_if_i.clk_gate),
        .array_select(sdc_link_if_i.array_select), .addr(sdc_link_if_i.addr),
        .termination_ctrl(sdc_link_if_i.termination_ctrl), .async_clear_n(sdc_link_if_i.async_clear_n));
    // ----------------------------------------------------------------
    // Clock, timeout and tasks
    // ----------------------------------------------------------------
    // Free running 25 MHz clock.
    always #20 core_clk = ~core_clk;
    // Cuts a hang short after far more cycles than the tests need.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            conclude();
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Sends one request, waits for the device strobe and checks kind and state.
    task automatic op(input sdc_cmd_t c, input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
                      input sdc_state_t st);
        int   n;
        logic seen;
        logic want;
        want = (c != SDC_CMD_IDLE);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_term = ~req_term;
        n = 0;
        while (req_ready !== 1'b1 && n < 10) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        seen = 1'b0;
        for (n = 0; n < 4 && !seen; n++) begin
            @(posedge core_clk);
            #1 seen = (cmd_strobe === 1'b1);
        end
        `CHK(seen, want)
        if (seen) `CHK(cmd_kind, c)
        `CHK(dev_state, st)
    endtask
    // Counts the cycles for which a burst keeps the device busy.
    task automatic burst(input int len);
        int n;
        n = 0;
        while (burst_busy === 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        `CHK(n, len)
    endtask
    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        `CHK(dev_state, SDC_ST_IDLE)
        `CHK(mode_zero, MODE_RESET)
        `CHK(sdc_link_if_i.chip_sel_n, 1'b1)
        $display("test reset done");
        op(SDC_CMD_MODE_SET, 3'h0, 16'h0001, SDC_ST_IDLE);
        `CHK(mode_zero, 16'h0001)
        op(SDC_CMD_MODE_SET, 3'h1, 16'hffff, SDC_ST_IDLE);
        `CHK(mode_zero, 16'h0001)
        op(SDC_CMD_RENEW, 3'h0, 16'h0000, SDC_ST_IDLE);
        op(SDC_CMD_CAL_LONG, 3'h0, 16'h0400, SDC_ST_IDLE);
        op(SDC_CMD_CAL_SHORT, 3'h0, 16'h0000, SDC_ST_IDLE);
        op(SDC_CMD_IDLE, 3'h0, 16'h0000, SDC_ST_IDLE);
        $display("test mode and calibration done");
        op(SDC_CMD_OPEN, 3'h2, 16'h1234, SDC_ST_ACTIVE);
        `CHK({cmd_bank, cmd_addr}, {3'h2, 16'h1234})
        op(SDC_CMD_READ, 3'h2, 16'h1bff, SDC_ST_BURST);
        `CHK({cmd_addr, cmd_chop_four, cmd_auto_close}, {16'h0bff, 2'h0})
        burst(BURST_EIGHT_LEN + 1);
        op(SDC_CMD_CLOSE, 3'h2, 16'h0000, SDC_ST_IDLE);
        op(SDC_CMD_OPEN, 3'h5, 16'h0042, SDC_ST_ACTIVE);
        op(SDC_CMD_WRITE, 3'h5, 16'h0400, SDC_ST_BURST);
        `CHK({cmd_addr, cmd_chop_four, cmd_auto_close}, {16'h0000, 2'h3})
        burst(CHOP_FOUR_LEN + 1);
        op(SDC_CMD_CLOSE_ALL, 3'h0, 16'h0400, SDC_ST_IDLE);
        $display("test bursts done");
        op(SDC_CMD_SLEEP, 3'h0, 16'h0000, SDC_ST_PD_PRECHARGE);
        op(SDC_CMD_WAKE, 3'h0, 16'h0000, SDC_ST_IDLE);
        op(SDC_CMD_OPEN, 3'h1, 16'h0007, SDC_ST_ACTIVE);
        op(SDC_CMD_SLEEP, 3'h0, 16'h0000, SDC_ST_PD_ACTIVE);
        op(SDC_CMD_WAKE, 3'h0, 16'h0000, SDC_ST_ACTIVE);
        op(SDC_CMD_CLOSE_ALL, 3'h0, 16'h0400, SDC_ST_IDLE);
        op(SDC_CMD_SR_ENTER, 3'h0, 16'h0000, SDC_ST_SELF_RENEW);
        op(SDC_CMD_WAKE, 3'h0, 16'h0000, SDC_ST_IDLE);
        $display("test power states done");
        conclude();
    end
endmodule // tb_sdc_command_decode
